// *** verilog/fetch_pipe_params.svh ***
// constants for the four-phase fetch/execute pipeline control
// assumes inclusion by bare name from the design file
`ifndef FETCH_PIPE_PARAMS_SVH
`define FETCH_PIPE_PARAMS_SVH
`define PH_COUNT        4
`define DATA_W          8
`define PC_W            15
`define PAGE_W          8
`define SST_LONG_CYC    1024
`define SST_SHORT_CYC   1
`define SST_SHORT_MAX   2
`define PC_RESET        15'h0000
`define ACC_RESET       8'h00
`endif

// *** verilog/fetch_pipe_pkg.sv ***
// types for the four-phase fetch/execute pipeline control
// assumes nothing beyond a SystemVerilog compiler
package fetch_pipe_pkg;
  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } phase_t;
  typedef enum logic [2:0] {
    ST_STARTUP = 3'h1,
    ST_RUN     = 3'h2,
    ST_SLEEP   = 3'h4
  } run_state_t;
  typedef enum logic [2:0] {
    OP_SEQ    = 3'h0,
    OP_JUMP   = 3'h1,
    OP_SKIP   = 3'h2,
    OP_PCLWR  = 3'h3,
    OP_SLEEP  = 3'h4
  } op_class_t;
endpackage

// *** verilog/fetch_pipe.sv ***
// four-phase instruction cycle timing, fetch/execute overlap and start-up timer
// assumes REF_CLK is the system clock; instruction word and decode come from the core
`timescale 1ns/10ps
`default_nettype none
`include "fetch_pipe_params.svh"

// Behaviour
// RL1: four non-overlapping phases form one instruction cycle
// RL2: phase one increments PC, starts fetch
// RL3: phases two to four decode and execute
// RL4: fetch overlaps execute, one per cycle
// RL5: PC-loading instructions take two cycles
// RL6: eight-bit datapath for all ALU work
// RL7: transfers pass through accumulator and ALU
// RL8: special registers reachable direct or indirect
// RL9: power-on holds execution 1024 clocks
// RL10: crystal wake-up waits 1024 clocks
// RL11: RC or external clock wake-up 1-2 clocks
// RL12: taken skip discards prefetch, idle cycle
// RL13: PC low write jumps in page, idle
// RL14: startup or reset empties pipe, phase restarts
module fetch_pipe #(
  parameter int SST_CYCLES = `SST_LONG_CYC,
  parameter int PC_WIDTH   = `PC_W
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic                  WAKE,
  input  wire logic                  FAST_OSC,
  input  wire logic [2:0]            OP_CLASS,
  input  wire logic                  SKIP_TAKEN,
  input  wire logic [PC_WIDTH-1:0]   JUMP_TARGET,
  input  wire logic [`DATA_W-1:0]    PCL_WDATA,
  input  wire logic [`DATA_W-1:0]    ALU_RESULT,
  input  wire logic                  ACC_LOAD,
  input  wire logic                  IND_SEL,
  input  wire logic [`DATA_W-1:0]    DIRECT_ADDR,
  input  wire logic [`DATA_W-1:0]    POINTER,
  output logic [3:0]                 PHASE,
  output logic [PC_WIDTH-1:0]        PC,
  output logic                       FETCH_STROBE,
  output logic                       EXEC_VALID,
  output logic                       EXEC_STROBE,
  output logic                       CORE_RUN,
  output logic [`DATA_W-1:0]         ACC,
  output logic [`DATA_W-1:0]         DATA_ADDR
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic wake_s1_q, wake_s2_q, fast_s1_q, fast_s2_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= WAKE;
      wake_s2_q <= wake_s1_q;
      fast_s1_q <= FAST_OSC;
      fast_s2_q <= fast_s1_q;
    end
  end

  // ************************************************************
  // instruction class decode
  // ************************************************************
  function automatic logic op_is(input logic [2:0] cls, input fetch_pipe_pkg::op_class_t op);
    return cls == 3'(op);
  endfunction

  // ************************************************************
  // start-up timer and run state
  // ************************************************************
  fetch_pipe_pkg::run_state_t run_q;
  logic [10:0]                sst_cnt_q;
  logic [10:0]                sst_load;
  logic                       sleep_req;
  logic                       cycle_end;

  assign sleep_req = cycle_end && EXEC_VALID && op_is(OP_CLASS, fetch_pipe_pkg::OP_SLEEP);
  assign sst_load  = fast_s2_q ? 11'(`SST_SHORT_CYC) : 11'(SST_CYCLES);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      // RL9 power-on hold
      run_q     <= fetch_pipe_pkg::ST_STARTUP;
      sst_cnt_q <= 11'(`SST_LONG_CYC);
    end else begin
      case (run_q)
        fetch_pipe_pkg::ST_STARTUP: begin
          if (sst_cnt_q <= 11'h001) begin
            run_q <= fetch_pipe_pkg::ST_RUN;
          end else begin
            sst_cnt_q <= sst_cnt_q - 11'h001;
          end
        end
        fetch_pipe_pkg::ST_RUN: begin
          if (sleep_req) begin
            run_q <= fetch_pipe_pkg::ST_SLEEP;
          end
        end
        fetch_pipe_pkg::ST_SLEEP: begin
          if (wake_s2_q) begin
            // RL10 crystal wake delay
            // RL11 rc wake delay
            run_q     <= fetch_pipe_pkg::ST_STARTUP;
            sst_cnt_q <= sst_load;
          end
        end
        default: begin
          run_q <= fetch_pipe_pkg::ST_STARTUP;
        end
      endcase
    end
  end

  assign CORE_RUN = (run_q == fetch_pipe_pkg::ST_RUN);

  // ************************************************************
  // phase generator
  // ************************************************************
  fetch_pipe_pkg::phase_t phase_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      phase_q <= fetch_pipe_pkg::PH_T1;
    end else if (!CORE_RUN) begin
      // RL14 phase restart
      phase_q <= fetch_pipe_pkg::PH_T1;
    end else begin
      // RL1 one-hot rotation
      case (phase_q)
        fetch_pipe_pkg::PH_T1: phase_q <= fetch_pipe_pkg::PH_T2;
        fetch_pipe_pkg::PH_T2: phase_q <= fetch_pipe_pkg::PH_T3;
        fetch_pipe_pkg::PH_T3: phase_q <= fetch_pipe_pkg::PH_T4;
        fetch_pipe_pkg::PH_T4: phase_q <= fetch_pipe_pkg::PH_T1;
        default:               phase_q <= fetch_pipe_pkg::PH_T1;
      endcase
    end
  end

  assign PHASE     = CORE_RUN ? phase_q : 4'h0;
  assign cycle_end = CORE_RUN && (phase_q == fetch_pipe_pkg::PH_T4);

  // ************************************************************
  // program counter and pipeline valid
  // ************************************************************
  logic                flush;
  logic                second_q;
  logic [PC_WIDTH-1:0] pc_q;
  logic                exec_valid_q;

  // RL5 branch costs a cycle
  // RL12 skip flushes prefetch
  // RL13 pc low write flushes
  assign flush = EXEC_VALID && (op_is(OP_CLASS, fetch_pipe_pkg::OP_JUMP) ||
                 op_is(OP_CLASS, fetch_pipe_pkg::OP_PCLWR) ||
                 (op_is(OP_CLASS, fetch_pipe_pkg::OP_SKIP) && SKIP_TAKEN));

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_q <= PC_WIDTH'(`PC_RESET);
    end else if (cycle_end && flush && op_is(OP_CLASS, fetch_pipe_pkg::OP_JUMP)) begin
      pc_q <= JUMP_TARGET;
    end else if (cycle_end && flush && op_is(OP_CLASS, fetch_pipe_pkg::OP_PCLWR)) begin
      // RL13 jump within page
      pc_q <= {pc_q[PC_WIDTH-1:`PAGE_W], PCL_WDATA};
    end else if (CORE_RUN && phase_q == fetch_pipe_pkg::PH_T1) begin
      // RL2 increment at phase one
      pc_q <= pc_q + PC_WIDTH'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || !CORE_RUN) begin
      // RL14 pipe empty
      exec_valid_q <= 1'b0;
      second_q     <= 1'b0;
    end else if (cycle_end) begin
      // RL4 prefetched word moves to execute
      exec_valid_q <= !flush && !sleep_req;
      second_q     <= flush;
    end
  end

  assign PC           = pc_q;
  assign EXEC_VALID   = exec_valid_q;
  assign FETCH_STROBE = CORE_RUN && (phase_q == fetch_pipe_pkg::PH_T1);
  // RL3 execute in phases two to four
  assign EXEC_STROBE  = CORE_RUN && exec_valid_q && (phase_q != fetch_pipe_pkg::PH_T1);

  // ************************************************************
  // accumulator and data addressing
  // ************************************************************
  logic [`DATA_W-1:0] acc_q;
  logic [`DATA_W-1:0] addr_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_q <= `ACC_RESET;
    end else if (EXEC_STROBE && phase_q == fetch_pipe_pkg::PH_T4 && ACC_LOAD) begin
      // RL6 eight-bit result
      // RL7 via accumulator
      acc_q <= ALU_RESULT;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      addr_q <= `ACC_RESET;
    end else if (EXEC_STROBE && phase_q == fetch_pipe_pkg::PH_T2) begin
      // RL8 direct or indirect
      addr_q <= IND_SEL ? POINTER : DIRECT_ADDR;
    end
  end

  assign ACC       = acc_q;
  assign DATA_ADDR = addr_q;

  // ************************************************************
  // assertion helpers
  // ************************************************************
  // counts non-run cycles from reset release, saturating at 7FF; por_q marks those before the first run cycle
  logic [10:0] hold_cnt_q;
  logic        por_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      hold_cnt_q <= 11'h000;
      por_q      <= 1'b1;
    end else if (CORE_RUN) begin
      por_q      <= 1'b0;
    end else if (hold_cnt_q != 11'h7FF) begin
      hold_cnt_q <= hold_cnt_q + 11'h001;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_phase_onehot: assert property (@(posedge REF_CLK) disable iff (RST) // RL1
    CORE_RUN |-> $onehot(phase_q)) else $error("phase not one-hot");
  a_phase_cycle: assert property (@(posedge REF_CLK) disable iff (RST) // RL1
    (CORE_RUN && phase_q == fetch_pipe_pkg::PH_T1) ##1 CORE_RUN[*3] |-> phase_q == fetch_pipe_pkg::PH_T4)
    else $error("phase sequence broken");
  a_pc_increment: assert property (@(posedge REF_CLK) disable iff (RST) // RL2
    (FETCH_STROBE) |=> pc_q == $past(pc_q) + PC_WIDTH'(1)) else $error("pc did not increment");
  a_exec_phase: assert property (@(posedge REF_CLK) disable iff (RST) // RL3
    EXEC_STROBE |-> phase_q != fetch_pipe_pkg::PH_T1) else $error("execute in phase one");
  a_branch_bubble: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
    (cycle_end && flush && CORE_RUN) |=> !EXEC_VALID[*4]) else $error("no idle after branch");
  a_seq_overlap: assert property (@(posedge REF_CLK) disable iff (RST) // RL4
    (cycle_end && EXEC_VALID && !flush && !sleep_req) |=> EXEC_VALID) else $error("overlap lost");
  a_page_jump: assert property (@(posedge REF_CLK) disable iff (RST) // RL13
    (cycle_end && EXEC_VALID && OP_CLASS == 3'(fetch_pipe_pkg::OP_PCLWR)) |=>
    pc_q[PC_WIDTH-1:`PAGE_W] == $past(pc_q[PC_WIDTH-1:`PAGE_W])) else $error("page left");
  a_startup_empty: assert property (@(posedge REF_CLK) disable iff (RST) // RL14
    !CORE_RUN |-> !EXEC_VALID && PHASE == 4'h0) else $error("pipe busy in startup");
  a_fast_wake: assert property (@(posedge REF_CLK) disable iff (RST) // RL11
    (run_q == fetch_pipe_pkg::ST_SLEEP && wake_s2_q && fast_s2_q) |-> ##[1:2] CORE_RUN)
    else $error("fast wake too slow");
  a_power_hold: assert property (@(posedge REF_CLK) // RL9
    $fell(RST) |-> !CORE_RUN[*8]) else $error("startup too short");
  a_exec_start: assert property (@(posedge REF_CLK) disable iff (RST) // RL3
    $rose(EXEC_STROBE) |-> phase_q == fetch_pipe_pkg::PH_T2) else $error("execute did not start in phase two");
  a_fetch_once: assert property (@(posedge REF_CLK) disable iff (RST) // RL4
    FETCH_STROBE |=> !FETCH_STROBE[*3]) else $error("second fetch in one cycle");
  a_jump_load: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
    (cycle_end && EXEC_VALID && op_is(OP_CLASS, fetch_pipe_pkg::OP_JUMP)) |=>
    pc_q == $past(JUMP_TARGET)) else $error("jump target not loaded");
  a_branch_resume: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
    (cycle_end && second_q) |=> EXEC_VALID && !second_q) else $error("branch did not resume");
  a_acc_load: assert property (@(posedge REF_CLK) disable iff (RST) // RL7
    (EXEC_STROBE && phase_q == fetch_pipe_pkg::PH_T4 && ACC_LOAD) |=>
    ACC == $past(ALU_RESULT)) else $error("accumulator not loaded");
  a_addr_select: assert property (@(posedge REF_CLK) disable iff (RST) // RL8
    (EXEC_STROBE && phase_q == fetch_pipe_pkg::PH_T2) |=>
    DATA_ADDR == ($past(IND_SEL) ? $past(POINTER) : $past(DIRECT_ADDR)))
    else $error("data address not selected");
  a_power_count: assert property (@(posedge REF_CLK) disable iff (RST) // RL9
    ($rose(CORE_RUN) && por_q) |-> hold_cnt_q == 11'(`SST_LONG_CYC)) else $error("power-on hold length wrong");
  a_crystal_wake: assert property (@(posedge REF_CLK) disable iff (RST) // RL10
    (run_q == fetch_pipe_pkg::ST_SLEEP && wake_s2_q && !fast_s2_q) |=>
    sst_cnt_q == 11'(SST_CYCLES)) else $error("crystal wake count wrong");
  a_skip_flush: assert property (@(posedge REF_CLK) disable iff (RST) // RL12
    (cycle_end && EXEC_VALID && op_is(OP_CLASS, fetch_pipe_pkg::OP_SKIP) && SKIP_TAKEN) |=> !EXEC_VALID)
    else $error("taken skip kept prefetch");
  a_skip_keep: assert property (@(posedge REF_CLK) disable iff (RST) // RL12
    (cycle_end && EXEC_VALID && op_is(OP_CLASS, fetch_pipe_pkg::OP_SKIP) && !SKIP_TAKEN) |=> EXEC_VALID)
    else $error("untaken skip lost prefetch");
  a_sleep_stop: assert property (@(posedge REF_CLK) disable iff (RST) // RL14
    sleep_req |=> !CORE_RUN && !EXEC_VALID) else $error("core ran on after sleep");

  c_branch: cover property (@(posedge REF_CLK) cycle_end && flush);
  c_skip: cover property (@(posedge REF_CLK) cycle_end && EXEC_VALID && OP_CLASS == 3'h2 && SKIP_TAKEN);
  c_wake: cover property (@(posedge REF_CLK) run_q == fetch_pipe_pkg::ST_SLEEP ##1 !CORE_RUN ##[1:8] CORE_RUN);
  c_pcl_write: cover property (@(posedge REF_CLK)
    cycle_end && EXEC_VALID && op_is(OP_CLASS, fetch_pipe_pkg::OP_PCLWR));
  c_crystal_wake: cover property (@(posedge REF_CLK) run_q == fetch_pipe_pkg::ST_SLEEP && wake_s2_q && !fast_s2_q);

endmodule

`default_nettype wire

// *** test/fetch_pipe_test.sv ***
// self-checking bench for the four-phase fetch/execute pipeline control
// assumes the design files are compiled first; inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
`include "fetch_pipe_params.svh"

module fetch_pipe_test;
  logic                REF_CLK     = 1'b0;
  logic                RST         = 1'b1;
  logic                WAKE        = 1'b0;
  logic                FAST_OSC    = 1'b0;
  logic [2:0]          OP_CLASS    = 3'h0;
  logic                SKIP_TAKEN  = 1'b0;
  logic [`PC_W-1:0]    JUMP_TARGET = 15'h0000;
  logic [7:0]          PCL_WDATA   = 8'h00;
  logic [7:0]          ALU_RESULT  = 8'h00;
  logic                ACC_LOAD    = 1'b0;
  logic                IND_SEL     = 1'b0;
  logic [7:0]          DIRECT_ADDR = 8'h00;
  logic [7:0]          POINTER     = 8'h00;
  logic [3:0]          PHASE;
  logic [`PC_W-1:0]    PC;
  logic                FETCH_STROBE, EXEC_VALID, EXEC_STROBE, CORE_RUN;
  logic [7:0]          ACC, DATA_ADDR;
  logic                ev_seen;
  logic [`PC_W-1:0]    pc_seen;
  int                  errors = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;

  // short wake-up count keeps the crystal wake case brief
  fetch_pipe #(.SST_CYCLES(16)) dut (.REF_CLK(REF_CLK), .RST(RST), .WAKE(WAKE), .FAST_OSC(FAST_OSC),
    .OP_CLASS(OP_CLASS), .SKIP_TAKEN(SKIP_TAKEN), .JUMP_TARGET(JUMP_TARGET), .PCL_WDATA(PCL_WDATA),
    .ALU_RESULT(ALU_RESULT), .ACC_LOAD(ACC_LOAD), .IND_SEL(IND_SEL), .DIRECT_ADDR(DIRECT_ADDR),
    .POINTER(POINTER), .PHASE(PHASE), .PC(PC), .FETCH_STROBE(FETCH_STROBE), .EXEC_VALID(EXEC_VALID),
    .EXEC_STROBE(EXEC_STROBE), .CORE_RUN(CORE_RUN), .ACC(ACC), .DATA_ADDR(DATA_ADDR));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  always #4 REF_CLK = ~REF_CLK;

  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  task automatic results;
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  task automatic tick;
    @(posedge REF_CLK);
    #1;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (CORE_RUN !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
  endtask

  // drives one instruction from T2 through the edge that ends T4
  task automatic instr(input logic [2:0] op, input logic skp, input logic [`PC_W-1:0] tgt,
                       input logic [7:0] pc_low_byte, input logic [7:0] alu, input logic ld, input logic ind);
    int n;
    n = 0;
    tick();
    while (PHASE !== fetch_pipe_pkg::PH_T2 && n < 20) begin
      tick();
      n++;
    end
    ev_seen = EXEC_VALID;
    pc_seen = PC;
    OP_CLASS = op;
    SKIP_TAKEN = skp;
    JUMP_TARGET = tgt;
    PCL_WDATA = pc_low_byte;
    ALU_RESULT = alu;
    ACC_LOAD = ld;
    IND_SEL = ind;
    repeat (3) tick();
    OP_CLASS = fetch_pipe_pkg::OP_SEQ;
    SKIP_TAKEN = 1'b0;
    ACC_LOAD = 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_startup;
    int n;
    repeat (6) @(posedge REF_CLK);
    #1 RST = 1'b0;
    tick();
    chk(PHASE, 16'h0000);
    chk(EXEC_VALID, 16'h0000);
    chk(PC, 16'h0000);
    wait_run(n);
    chk_rng(n + 1, 1023, 1025);
  endtask

  task automatic t_phases;
    logic [`PC_W-1:0] p;
    p = PC;
    for (int i = 0; i < 8; i++) begin
      chk(PHASE, 16'h0001 << (i % 4));
      chk(FETCH_STROBE, (i % 4 == 0));
      chk(EXEC_STROBE, i > 4);
      if (i == 4) chk(PC, p + 1);
      tick();
    end
  endtask

  task automatic t_jump;
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 8'hA5, 1, 0);
    chk(ACC, 8'hA5);
    instr(fetch_pipe_pkg::OP_JUMP, 0, 15'h1234, 0, 0, 0, 0);
    chk(PC, 15'h1234);
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 8'hEE, 1, 0);
    chk(ev_seen, 0);
    chk(pc_seen, 15'h1235);
    chk(ACC, 8'hA5);
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 0, 0, 0);
    chk(ev_seen, 1);
  endtask

  task automatic t_skip_pcl;
    instr(fetch_pipe_pkg::OP_SKIP, 1, 0, 0, 0, 0, 0);
    instr(fetch_pipe_pkg::OP_SKIP, 0, 0, 0, 0, 0, 0);
    chk(ev_seen, 0);
    // untaken skip must keep the prefetched word
    instr(fetch_pipe_pkg::OP_SKIP, 0, 0, 0, 0, 0, 0);
    chk(ev_seen, 1);
    instr(fetch_pipe_pkg::OP_PCLWR, 0, 0, 8'h5A, 0, 0, 0);
    chk(ev_seen, 1);
    chk(PC, {pc_seen[`PC_W-1:8], 8'h5A});
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 0, 0, 0);
    chk(ev_seen, 0);
  endtask

  task automatic t_addr;
    POINTER = 8'h3C;
    DIRECT_ADDR = 8'hC3;
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 0, 0, 1);
    chk(DATA_ADDR, 8'h3C);
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 0, 0, 0);
    chk(DATA_ADDR, 8'hC3);
  endtask

  task automatic t_wake(input logic fast, input int lo, input int hi);
    int n;
    FAST_OSC = fast;
    // a wake leaves a dummy cycle, so sleep only from a valid slot
    instr(fetch_pipe_pkg::OP_SEQ, 0, 0, 0, 0, 0, 0);
    instr(fetch_pipe_pkg::OP_SLEEP, 0, 0, 0, 0, 0, 0);
    repeat (2) tick();
    chk(CORE_RUN, 0);
    chk(PHASE, 0);
    WAKE = 1'b1;
    wait_run(n);
    WAKE = 1'b0;
    chk_rng(n, lo, hi);
    chk(PHASE, fetch_pipe_pkg::PH_T1);
  endtask

  initial begin
    t_startup();
    t_phases();
    t_jump();
    t_skip_pcl();
    t_addr();
    t_wake(1'b1, 2, 5);
    t_wake(1'b0, 16, 20);
    results();
  end
endmodule

`default_nettype wire
